//--- nlc_nvm_lock_cfg.sv
/*
  Lock bits, protection modes and the four flash sections as seen by the
  external programmer, with configuration latching and oscillator trim load.
  Assumes the programming interface drives the access and key ports on the
  system clock; requests are single-cycle strobes taken only while idle.
*/
// Notes on behaviour
// [R1] two lock bits at 1:0, rest read one
// [R2] one unprogrammed, zero programmed adds protection
// [R3] only chip erase returns lock bits high
// [R4] lock mode 1 gives no protection
// [R5] mode 2 refuses flash programming, locks configuration
// [R6] mode 3 blocks programming and verification reads
// [R7] programmer writes configuration before lock bits
// [R8] large code: 64 pages of 8 words
// [R9] small code: 32 pages, same split
// [R10] config, signature, calibration sizes; last two read-only
// [R11] configuration byte is low byte, word zero
// [R12] clock out, watchdog on, reset pin disable
// [R13] chip erase leaves configuration bits alone
// [R14] lower lock bit programmed blocks configuration changes
// [R15] configuration latched at reset or mode exit
// [R16] three signature bytes in words zero, one
// [R17] calibration low byte loads trim at reset
// [R18] lock bits clear after code fully erased
// [R19] programming needs key; disable bit ends it
// [R20] mode 3 code reads return filler
`timescale 1ns/10ps
`default_nettype none

module nlc_nvm_lock_cfg #(
  parameter int         CODE_BYTES = 1024,
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_CODE_1 = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE_2 = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL_VALUE  = 8'h80
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        prog_key_valid_i,
  input  wire logic [63:0] prog_key_i,
  input  wire logic        prog_disable_i,
  input  wire logic        prog_req_i,
  input  wire logic        prog_write_i,
  input  wire logic [2:0]  prog_sect_i,
  input  wire logic [9:0]  prog_addr_i,
  input  wire logic [7:0]  prog_wdata_i,
  input  wire logic [1:0]  prog_cmd_i,
  output logic             prog_ack_o,
  output logic             prog_err_o,
  output logic      [7:0]  prog_rdata_o,
  output logic             prog_busy_o,
  output logic             programming_enabled_flag_o,
  output logic      [7:0]  lock_protection_byte_o,
  output logic      [1:0]  lock_mode_o,
  output logic             clk_out_en_o,
  output logic             watchdog_force_on_o,
  output logic             reset_pin_disable_o,
  output logic      [7:0]  oscillator_trim_register_o
);
  localparam int CODE_WORDS = CODE_BYTES / 2;
  localparam int CODE_AW    = $clog2(CODE_WORDS);

  // pick one byte of a word by the byte-select bit
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte

  nlc_pkg::nlc_state_e state_q;
  // non-volatile cells power up erased; only their own process writes them
  logic [1:0]  lock_q = nlc_pkg::LOCK_ERASED;
  logic [15:0] cfg_mem_q [nlc_pkg::CFG_WORDS] = '{default: nlc_pkg::ERASED_WORD};
  logic [2:0]  cfg_latch_q;
  logic [7:0]  trim_q;
  logic [7:0]  tmp_lo_q;
  logic        en_q;
  logic        ack_q;
  logic        err_q;
  logic [7:0]  rdata_q;
  logic        busy_q;
  logic        chip_erase_q;
  logic [1:0]  mode_q;
  logic [15:0] code_rword;
  logic        erase_busy;
  logic        erase_done;

  // address split: byte select, word in page, page
  wire         hi_w        = prog_addr_i[nlc_pkg::BYTE_SEL_POS];
  wire [2:0]   word_in_page_address = prog_addr_i[nlc_pkg::WORD_SEL_MSB:nlc_pkg::WORD_SEL_LSB];
  wire [5:0]   page_w      = prog_addr_i[nlc_pkg::PAGE_MSB:nlc_pkg::PAGE_LSB]; // [R8]
  wire [CODE_AW-1:0] code_word_in_page_address = prog_addr_i[CODE_AW:1]; // [R9]
  wire         code_in_range = ({4'h0, page_w} < 10'(CODE_WORDS / nlc_pkg::PAGE_WORDS));
  wire         sig_page_w  = prog_addr_i[4];

  // protection decode from the lock cells
  wire         lock_bit_low  = lock_q[nlc_pkg::LOCK_BIT_LOW_POS];
  wire         lock_bit_high = lock_q[nlc_pkg::LOCK_BIT_HIGH_POS];
  wire         code_locked   = ~lock_bit_low | ~lock_bit_high; // [R4] [R5] [R2]
  wire         verify_locked = ~lock_bit_high;                 // [R6]
  wire         cfg_locked    = ~lock_bit_low;                  // [R14] [R5]
  wire [1:0]   mode_w        = (lock_q == 2'h3) ? 2'd1 :
                               (lock_q == 2'h2) ? 2'd2 : 2'd3;

  // request classification
  wire         idle_w    = (state_q == nlc_pkg::ST_IDLE);
  wire         take_w    = prog_req_i & idle_w;
  wire         is_code   = (prog_sect_i == nlc_pkg::SECT_CODE) & code_in_range;
  wire         is_cfg    = (prog_sect_i == nlc_pkg::SECT_CFG);
  wire         is_sig    = (prog_sect_i == nlc_pkg::SECT_SIG);
  wire         is_cal    = (prog_sect_i == nlc_pkg::SECT_CAL);
  wire         is_lock   = (prog_sect_i == nlc_pkg::SECT_LOCK);
  wire         cmd_wr    = (prog_cmd_i == nlc_pkg::CMD_WORD_WRITE);
  wire         cmd_serase = (prog_cmd_i == nlc_pkg::CMD_SECTION_ERASE);
  wire         cmd_chip  = (prog_cmd_i == nlc_pkg::CMD_CHIP_ERASE);

  // operations started by a high-byte write; code and config ones carry a lock guard, chip erase and lock write none
  wire         op_code_wr  = is_code & cmd_wr & ~code_locked;     // [R5] [R6]
  wire         op_code_er  = is_code & cmd_serase & ~code_locked; // [R5]
  wire         op_chip     = is_code & cmd_chip;                  // [R3]
  wire         op_cfg_wr   = is_cfg & cmd_wr & ~cfg_locked;       // [R14]
  wire         op_cfg_er   = is_cfg & cmd_serase & ~cfg_locked;   // [R13] [R14]
  wire         op_lock_wr  = is_lock & cmd_wr;
  wire         hi_ok       = op_code_wr | op_code_er | op_chip | op_cfg_wr | op_cfg_er | op_lock_wr;
  wire         lo_ok       = is_code | is_cfg | is_lock;          // [R10]
  wire         wr_ok       = en_q & (hi_w ? hi_ok : lo_ok);       // [R19]
  wire         start_w     = take_w & prog_write_i & hi_w & wr_ok;
  wire         lo_store_w  = take_w & prog_write_i & ~hi_w & wr_ok;
  wire         refuse_w    = prog_req_i & (~idle_w | (prog_write_i & ~wr_ok));

  // new word ANDs into the cells: programming only clears bits
  wire [15:0]  new_word    = {prog_wdata_i, tmp_lo_q};
  wire [15:0]  code_wdata  = code_rword & new_word;
  wire         code_wr_en  = start_w & op_code_wr;
  wire         erase_go    = start_w & (op_code_er | op_chip);

  // read data by section; reserved bytes read erased
  wire [7:0]   code_rd = verify_locked ? nlc_pkg::CODE_FILLER     // [R20] [R6]
                                       : pick_byte(code_rword, hi_w);
  wire [7:0]   cfg_rd  = pick_byte(cfg_mem_q[word_in_page_address], hi_w);
  wire [15:0]  sig_w   = sig_page_w ? nlc_pkg::ERASED_WORD :
                         (word_in_page_address == 3'h0) ? {DEV_CODE_1, MAKER_CODE} :  // [R16]
                         (word_in_page_address == 3'h1) ? {nlc_pkg::ERASED_BYTE, DEV_CODE_2} :
                         nlc_pkg::ERASED_WORD;
  wire [15:0]  cal_w   = (word_in_page_address == 3'h0) ? {nlc_pkg::ERASED_BYTE, CAL_VALUE}
                                                         : nlc_pkg::ERASED_WORD;
  wire [7:0]   lock_rd = hi_w ? nlc_pkg::ERASED_BYTE
                              : {nlc_pkg::LOCK_UNUSED_ONES, lock_q};  // [R1]
  wire [7:0]   read_mux = is_code ? code_rd :
                          is_cfg  ? cfg_rd :
                          is_sig  ? pick_byte(sig_w, hi_w) :
                          is_cal  ? pick_byte(cal_w, hi_w) :
                          is_lock ? lock_rd : nlc_pkg::ERASED_BYTE;

  // key handling: the right key enables, the disable strobe ends the mode
  wire         key_ok_w  = prog_key_valid_i & (prog_key_i == nlc_pkg::PROG_KEY);
  wire         exit_w    = en_q & prog_disable_i;                     // [R19]

  nlc_code_store #(
    .WORDS (CODE_WORDS),
    .AW    (CODE_AW)
  ) u_code (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .addr_i        (code_word_in_page_address),
    .rdata_o       (code_rword),
    .wr_en_i       (code_wr_en),
    .wr_data_i     (code_wdata),
    .erase_start_i (erase_go),
    .erase_busy_o  (erase_busy),
    .erase_done_o  (erase_done)
  );

  // non-volatile lock cells: writes only clear, erase only after code gone
  always_ff @(posedge clk_sys_i) begin
    if (state_q == nlc_pkg::ST_ERASE && erase_done && chip_erase_q) begin
      lock_q <= nlc_pkg::LOCK_ERASED; // [R18] [R3]
    end else if (start_w && op_lock_wr) begin
      lock_q <= lock_q & tmp_lo_q[1:0]; // [R2] [R3]
    end
  end

  // configuration section cells; untouched by chip erase
  always_ff @(posedge clk_sys_i) begin
    if (start_w && op_cfg_er) begin
      for (int i = 0; i < nlc_pkg::CFG_WORDS; i++) begin
        cfg_mem_q[i] <= nlc_pkg::ERASED_WORD; // [R13]
      end
    end else if (start_w && op_cfg_wr) begin
      cfg_mem_q[word_in_page_address] <= cfg_mem_q[word_in_page_address] & new_word; // [R11]
    end
  end

  // sequencing: boot load, idle, erase wait
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q      <= nlc_pkg::ST_BOOT;
      chip_erase_q <= 1'b0;
    end else begin
      case (state_q)
        nlc_pkg::ST_BOOT: begin
          state_q <= nlc_pkg::ST_IDLE;
        end
        nlc_pkg::ST_IDLE: begin
          if (erase_go) begin
            state_q      <= nlc_pkg::ST_ERASE;
            chip_erase_q <= op_chip;
          end
        end
        nlc_pkg::ST_ERASE: begin
          if (erase_done) begin
            state_q      <= nlc_pkg::ST_IDLE;
            chip_erase_q <= 1'b0;
          end
        end
        default: begin
          state_q <= nlc_pkg::ST_BOOT;
        end
      endcase
    end
  end

  // operating latches: both loaded on boot, configuration also on leaving programming mode
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_latch_q <= nlc_pkg::CFG_LATCH_ERASED;
      trim_q      <= nlc_pkg::TRIM_RESET;
    end else begin
      if (state_q == nlc_pkg::ST_BOOT || exit_w) begin
        cfg_latch_q <= cfg_mem_q[0][2:0]; // [R15] [R11]
      end
      if (state_q == nlc_pkg::ST_BOOT) begin
        trim_q <= CAL_VALUE; // [R17]
      end
    end
  end

  // programming enable flag
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= 1'b0;
    end else if (prog_disable_i) begin
      en_q <= 1'b0; // [R19]
    end else if (key_ok_w) begin
      en_q <= 1'b1; // [R19]
    end
  end

  // access answers, temporary low byte and status
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
      rdata_q  <= 8'h00;
      tmp_lo_q <= nlc_pkg::ERASED_BYTE;
      busy_q   <= 1'b1;
      mode_q   <= 2'd1;
    end else begin
      ack_q  <= take_w & ~refuse_w;
      err_q  <= refuse_w;
      busy_q <= (state_q != nlc_pkg::ST_IDLE) | erase_go | erase_busy;
      mode_q <= mode_w;
      if (take_w && !prog_write_i) begin
        rdata_q <= read_mux;
      end
      if (lo_store_w) begin
        tmp_lo_q <= prog_wdata_i;
      end
    end
  end

  assign prog_ack_o                 = ack_q;
  assign prog_err_o                 = err_q;
  assign prog_rdata_o               = rdata_q;
  assign prog_busy_o                = busy_q;
  assign programming_enabled_flag_o = en_q;
  assign lock_protection_byte_o     = {nlc_pkg::LOCK_UNUSED_ONES, lock_q}; // [R1]
  assign lock_mode_o                = mode_q;
  // configuration bits act when programmed to zero
  assign clk_out_en_o               = ~cfg_latch_q[nlc_pkg::CFG_CLK_OUT_POS]; // [R12]
  assign watchdog_force_on_o        = ~cfg_latch_q[nlc_pkg::CFG_WDT_POS];     // [R12]
  assign reset_pin_disable_o        = ~cfg_latch_q[nlc_pkg::CFG_RST_DIS_POS]; // [R12]
  assign oscillator_trim_register_o = trim_q;
endmodule : nlc_nvm_lock_cfg

`default_nettype wire

//--- nlc_code_store.sv
/*
  Shared constants for the lock, configuration and section logic, plus the
  code section word store with its sequential section erase.
  Assumes one system clock and an active-high asynchronous reset. The store
  itself is non-volatile: reset touches only the erase sequencer.
*/
`default_nettype none

package nlc_pkg;
  // section select codes on the programmer access port
  localparam logic [2:0]  SECT_CODE         = 3'h0;
  localparam logic [2:0]  SECT_CFG          = 3'h1;
  localparam logic [2:0]  SECT_SIG          = 3'h2;
  localparam logic [2:0]  SECT_CAL          = 3'h3;
  localparam logic [2:0]  SECT_LOCK         = 3'h4;
  // controller commands
  localparam logic [1:0]  CMD_NONE          = 2'h0;
  localparam logic [1:0]  CMD_WORD_WRITE    = 2'h1;
  localparam logic [1:0]  CMD_SECTION_ERASE = 2'h2;
  localparam logic [1:0]  CMD_CHIP_ERASE    = 2'h3;
  // lock byte layout
  localparam int          LOCK_BIT_LOW_POS  = 0;
  localparam int          LOCK_BIT_HIGH_POS = 1;
  localparam logic [5:0]  LOCK_UNUSED_ONES  = 6'h3F;
  localparam logic [1:0]  LOCK_ERASED       = 2'h3;
  // configuration byte layout
  localparam int          CFG_CLK_OUT_POS   = 2;
  localparam int          CFG_WDT_POS       = 1;
  localparam int          CFG_RST_DIS_POS   = 0;
  localparam logic [2:0]  CFG_LATCH_ERASED  = 3'h7;
  // address split: byte, word in page, page
  localparam int          BYTE_SEL_POS      = 0;
  localparam int          WORD_SEL_LSB      = 1;
  localparam int          WORD_SEL_MSB      = 3;
  localparam int          PAGE_LSB          = 4;
  localparam int          PAGE_MSB          = 9;
  localparam int          PAGE_WORDS        = 8;
  localparam int          CFG_WORDS         = 8;
  localparam int          SIG_WORDS         = 8;
  localparam int          CAL_WORDS         = 8;
  // erased, filler and trim reset values
  localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
  localparam logic [15:0] ERASED_WORD       = 16'hFFFF;
  localparam logic [7:0]  CODE_FILLER       = 8'hFF;
  localparam logic [7:0]  TRIM_RESET        = 8'h00;
  // programming enable key
  localparam logic [63:0] PROG_KEY          = 64'h1289AB45CDD888FF;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_ERASE = 2'b10
  } nlc_state_e;
endpackage : nlc_pkg

`timescale 1ns/10ps

module nlc_code_store #(
  parameter int WORDS = 512,
  parameter int AW    = 9
) (
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  input  wire logic [AW-1:0] addr_i,
  output logic      [15:0]   rdata_o,
  input  wire logic          wr_en_i,
  input  wire logic [15:0]   wr_data_i,
  input  wire logic          erase_start_i,
  output logic               erase_busy_o,
  output logic               erase_done_o
);
  logic [15:0]   mem_q [WORDS] = '{default: nlc_pkg::ERASED_WORD}; // cells start erased
  logic [AW-1:0] cnt_q;
  logic          busy_q;
  logic          done_q;
  wire           last_w = (cnt_q == AW'(WORDS - 1));

  assign rdata_o      = mem_q[addr_i];
  assign erase_busy_o = busy_q;
  assign erase_done_o = done_q;

  // one word erased per clock while the sequencer runs
  always_ff @(posedge clk_sys_i) begin
    if (busy_q) begin
      mem_q[cnt_q] <= nlc_pkg::ERASED_WORD;
    end else if (wr_en_i) begin
      mem_q[addr_i] <= wr_data_i;
    end
  end

  // erase sequencer; done pulses once the last word is cleared
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q & last_w;
      if (busy_q) begin
        busy_q <= ~last_w;
        cnt_q  <= last_w ? '0 : cnt_q + AW'(1);
      end else if (erase_start_i) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end
    end
  end
endmodule : nlc_code_store

`default_nettype wire

//--- nlc_lock_chk.sv
/*
  checker: lock mode, refusal, erase order, latch and trim properties.
  assumes binding onto nlc_nvm_lock_cfg with one clock and active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module nlc_lock_chk #(
  parameter int         CODE_BYTES = 1024,
  parameter logic [7:0] CAL_VALUE  = 8'h80
) (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       prog_req_i,
  input wire logic       prog_write_i,
  input wire logic [2:0] prog_sect_i,
  input wire logic [9:0] prog_addr_i,
  input wire logic [1:0] prog_cmd_i,
  input wire logic       prog_ack_o,
  input wire logic       prog_err_o,
  input wire logic [7:0] prog_rdata_o,
  input wire logic       prog_busy_o,
  input wire logic       programming_enabled_flag_o,
  input wire logic [7:0] lock_protection_byte_o,
  input wire logic [1:0] lock_mode_o,
  input wire logic       clk_out_en_o,
  input wire logic       watchdog_force_on_o,
  input wire logic       reset_pin_disable_o,
  input wire logic [7:0] oscillator_trim_register_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // write requests, lock cells and the mode they imply
  wire logic       wr_w   = prog_req_i && prog_write_i && !prog_busy_o;
  wire logic [1:0] lck_w  = lock_protection_byte_o[1:0];
  wire logic [1:0] mode_w = (lck_w == 2'h3) ? 2'h1 : ((lck_w == 2'h2) ? 2'h2 : 2'h3);
  wire logic [2:0] cfg_w  = {clk_out_en_o, watchdog_force_on_o, reset_pin_disable_o};
  logic [15:0]     busy_cnt_q;
  // run length of the busy level
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= prog_busy_o ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  a_mode_decode : assert property (
    !$past(reset_i) |-> lock_mode_o == $past(mode_w)) else $error("lock mode wrong");
  a_write_needs_key : assert property (
    wr_w && !programming_enabled_flag_o |=> prog_err_o) else $error("write taken unkeyed");
  a_code_write_locked : assert property (
    wr_w && prog_sect_i == nlc_pkg::SECT_CODE && prog_addr_i[0] && lck_w != 2'h3
    && prog_cmd_i == nlc_pkg::CMD_WORD_WRITE |=> prog_err_o) else $error("locked code write");
  a_cfg_write_locked : assert property (
    wr_w && prog_sect_i == nlc_pkg::SECT_CFG && prog_addr_i[0] && !lck_w[0]
    && prog_cmd_i != nlc_pkg::CMD_NONE |=> prog_err_o) else $error("locked config write");
  a_lock_after_erase : assert property (
    $rose(lck_w[0]) || $rose(lck_w[1]) |-> busy_cnt_q >= CODE_BYTES / 2 - 2)
    else $error("lock bits lifted early");
  a_cfg_latch_cause : assert property (
    $changed(cfg_w) |-> $past(prog_busy_o) || $fell(programming_enabled_flag_o))
    else $error("config latch moved");
  a_trim_loaded : assert property (
    !prog_busy_o |-> oscillator_trim_register_o == CAL_VALUE) else $error("trim wrong");
  a_filler_read : assert property (
    prog_req_i && !prog_write_i && !prog_busy_o && !$past(prog_req_i) && !lck_w[1]
    && prog_sect_i == nlc_pkg::SECT_CODE |=> prog_ack_o && prog_rdata_o == 8'hFF)
    else $error("protected read leaked");
  c_chip_erase : cover property ($rose(lck_w[0]));
  c_cfg_refused : cover property (wr_w && prog_sect_i == nlc_pkg::SECT_CFG ##1 prog_err_o);
  c_mode_exit : cover property ($fell(programming_enabled_flag_o));
endmodule : nlc_lock_chk

bind nlc_nvm_lock_cfg nlc_lock_chk #(.CODE_BYTES(CODE_BYTES), .CAL_VALUE(CAL_VALUE))
  nlc_lock_chk_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .prog_req_i(prog_req_i),
  .prog_write_i(prog_write_i), .prog_sect_i(prog_sect_i), .prog_addr_i(prog_addr_i),
  .prog_cmd_i(prog_cmd_i), .prog_ack_o(prog_ack_o), .prog_err_o(prog_err_o),
  .prog_rdata_o(prog_rdata_o), .prog_busy_o(prog_busy_o),
  .programming_enabled_flag_o(programming_enabled_flag_o),
  .lock_protection_byte_o(lock_protection_byte_o), .lock_mode_o(lock_mode_o),
  .clk_out_en_o(clk_out_en_o), .watchdog_force_on_o(watchdog_force_on_o),
  .reset_pin_disable_o(reset_pin_disable_o),
  .oscillator_trim_register_o(oscillator_trim_register_o));
`default_nettype wire

//--- nlc_prog_model.sv
/*
  external programmer model: access strobes, key and exit strobes.
  assumes callers sit on a rising edge or just after; strobes last one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module nlc_prog_model (
  input  wire logic        clk_sys_i,
  output logic             key_valid_o,
  output logic      [63:0] key_o,
  output logic             disable_o,
  output logic             req_o,
  output logic             write_o,
  output logic      [2:0]  sect_o,
  output logic      [9:0]  addr_o,
  output logic      [7:0]  wdata_o,
  output logic      [1:0]  cmd_o
);
  // quiet bus at time zero
  initial begin
    {key_valid_o, disable_o, req_o, write_o} = 4'h0;
    {key_o, sect_o, addr_o, wdata_o, cmd_o} = '0;
  end
  // one request cycle; a burst ends with idle
  task automatic access(input logic w, input logic [2:0] s, input logic [9:0] a,
                        input logic [7:0] d, input logic [1:0] c);
    {req_o, write_o, sect_o, addr_o, wdata_o, cmd_o} <= {1'b1, w, s, a, d, c};
    @(posedge clk_sys_i);
  endtask : access
  // released bus: address and data turn to junk
  task automatic idle(input int n);
    repeat (n) begin
      req_o <= 1'b0;
      {addr_o, wdata_o} <= ~{addr_o, wdata_o};
      @(posedge clk_sys_i);
    end
  endtask : idle
  // key strobe, then a quiet cycle so strobes never abut
  task automatic send_key(input logic [63:0] k);
    {key_valid_o, key_o} <= {1'b1, k};
    @(posedge clk_sys_i);
    {key_valid_o, key_o} <= {1'b0, ~k};
    @(posedge clk_sys_i);
  endtask : send_key
  task automatic send_off;
    disable_o <= 1'b1;
    @(posedge clk_sys_i);
    disable_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask : send_off
endmodule : nlc_prog_model
`default_nettype wire

//--- nlc_nvm_lock_cfg_tb_top.sv
/*
  testbench top: programmer model drives the lock block; answers are checked
  against a queue of expected results. assumes design, checker and model files.
*/
`timescale 1ns/10ps
`default_nettype none
module nlc_nvm_lock_cfg_tb_top;
  localparam logic [2:0] CODE = nlc_pkg::SECT_CODE, CFG = nlc_pkg::SECT_CFG;
  localparam logic [2:0] SIG = nlc_pkg::SECT_SIG, CAL = nlc_pkg::SECT_CAL;
  localparam logic [2:0] LCK = nlc_pkg::SECT_LOCK;
  localparam logic [1:0] NO = nlc_pkg::CMD_NONE, WW = nlc_pkg::CMD_WORD_WRITE;
  localparam logic [1:0] SE = nlc_pkg::CMD_SECTION_ERASE, CE = nlc_pkg::CMD_CHIP_ERASE;
  localparam logic [9:0] OK = 10'h200, ER = 10'h000;
  logic             clk_sys_i = 1'b0;
  logic             reset_i = 1'b1;
  wire logic        kv, dis, req, wr, ack, err, busy, en, cko, wdo, rdo;
  wire logic [63:0] key;
  wire logic [2:0]  sect;
  wire logic [9:0]  addr;
  wire logic [7:0]  wdat, rdat, lockb, trim;
  wire logic [1:0]  cmd, mode;
  logic [9:0]       exp_q[$];
  logic [9:0]       a;
  logic [7:0]       wl, wh;
  int               error_cnt = 0;
  int               comparisons = 0;
  int               cyc = 0;

  nlc_nvm_lock_cfg #(.CODE_BYTES(32)) nlc_nvm_lock_cfg_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .prog_key_valid_i(kv), .prog_key_i(key),
    .prog_disable_i(dis), .prog_req_i(req), .prog_write_i(wr), .prog_sect_i(sect),
    .prog_addr_i(addr), .prog_wdata_i(wdat), .prog_cmd_i(cmd), .prog_ack_o(ack),
    .prog_err_o(err), .prog_rdata_o(rdat), .prog_busy_o(busy),
    .programming_enabled_flag_o(en), .lock_protection_byte_o(lockb), .lock_mode_o(mode),
    .clk_out_en_o(cko), .watchdog_force_on_o(wdo), .reset_pin_disable_o(rdo),
    .oscillator_trim_register_o(trim));
  nlc_prog_model nlc_prog_model_inst (.clk_sys_i(clk_sys_i), .key_valid_o(kv),
    .key_o(key), .disable_o(dis), .req_o(req), .write_o(wr), .sect_o(sect),
    .addr_o(addr), .wdata_o(wdat), .cmd_o(cmd));

  always #2 clk_sys_i = ~clk_sys_i;

  task automatic note(input string m);
    error_cnt++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : note
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    #1;
    comparisons++;
    if (got !== want) note($sformatf("status %h want %h", got, want));
    @(posedge clk_sys_i); // back on the edge so later stimulus stays edge aligned
  endtask : chk
  task automatic chk_ans(input logic [9:0] e);
    comparisons++;
    if (ack !== e[9] || err !== ~e[9] || (e[8] && rdat !== e[7:0]))
      note($sformatf("answer ack %b err %b data %h want %h", ack, err, rdat, e));
  endtask : chk_ans
  function automatic logic [9:0] rd(input logic [7:0] v);
    return {2'b11, v};
  endfunction : rd
  task automatic op(input logic w, input logic [2:0] s, input logic [9:0] ad,
                    input logic [7:0] d, input logic [1:0] c, input logic [9:0] e);
    exp_q.push_back(e);
    nlc_prog_model_inst.access(w, s, ad, d, c);
  endtask : op
  task automatic idle(input int n);
    nlc_prog_model_inst.idle(n);
  endtask : idle
  task automatic lock_set(input logic [7:0] v);
    op(1'b1, LCK, 10'h000, v, WW, OK);
    op(1'b1, LCK, 10'h001, 8'hFF, WW, OK);
    idle(3);
  endtask : lock_set
  task automatic wait_idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
      idle(1);
      #1;
    end
    chk({7'h00, busy}, 8'h00);
  endtask : wait_idle
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // answer watcher: oldest expectation against each ack or err
  always @(posedge clk_sys_i) begin
    #1;
    if (ack === 1'b1 || err === 1'b1) begin
      if (exp_q.size() == 0) note("answer with nothing expected");
      else chk_ans(exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      note("run timed out");
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'hA68C));
    a = 10'($urandom_range(31, 0)) & 10'h3FE;
    wl = 8'($urandom);
    wh = 8'($urandom);
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    wait_idle();
    chk(trim, 8'h80);
    chk(lockb, 8'hFF);
    chk({3'h0, cko, wdo, rdo, mode}, 8'h01);
    op(1'b0, SIG, 10'h000, 8'h00, NO, rd(8'hA5));
    op(1'b0, SIG, 10'h001, 8'h00, NO, rd(8'h5A));
    op(1'b0, SIG, 10'h002, 8'h00, NO, rd(8'h3C));
    op(1'b0, SIG, 10'h003, 8'h00, NO, rd(8'hFF));
    op(1'b0, CAL, 10'h000, 8'h00, NO, rd(8'h80));
    op(1'b1, CODE, 10'h001, 8'h00, WW, ER);
    idle(1);
    nlc_prog_model_inst.send_key(nlc_pkg::PROG_KEY);
    chk({7'h00, en}, 8'h01);
    op(1'b1, SIG, 10'h000, 8'h00, WW, ER);
    op(1'b1, CAL, 10'h000, 8'h00, WW, ER);
    op(1'b1, CODE, a, wl, WW, OK);
    op(1'b1, CODE, a | 10'h001, wh, WW, OK);
    op(1'b1, CODE, 10'h021, 8'h00, WW, ER);
    idle(1);
    op(1'b0, CODE, a, 8'h00, NO, rd(wl));
    op(1'b0, CODE, a | 10'h001, 8'h00, NO, rd(wh));
    op(1'b1, CFG, 10'h000, 8'hF8, WW, OK);
    op(1'b1, CFG, 10'h001, 8'hFF, WW, OK);
    idle(1);
    op(1'b0, CFG, 10'h000, 8'h00, NO, rd(8'hF8));
    op(1'b0, CFG, 10'h002, 8'h00, NO, rd(8'hFF));
    idle(2);
    chk({5'h00, cko, wdo, rdo}, 8'h00);
    nlc_prog_model_inst.send_off();
    chk({4'h0, en, cko, wdo, rdo}, 8'h07);
    nlc_prog_model_inst.send_key(nlc_pkg::PROG_KEY);
    lock_set(8'hFE);
    chk(lockb, 8'hFE);
    chk({6'h00, mode}, 8'h02);
    op(1'b1, CFG, 10'h000, 8'h00, WW, OK);
    op(1'b1, CFG, 10'h001, 8'hFF, WW, ER);
    op(1'b1, CODE, a | 10'h001, 8'h00, WW, ER);
    op(1'b0, CODE, a, 8'h00, NO, rd(wl));
    lock_set(8'hFC);
    op(1'b0, CODE, a, 8'h00, NO, rd(8'hFF));
    op(1'b0, SIG, 10'h000, 8'h00, NO, rd(8'hA5));
    op(1'b0, CFG, 10'h000, 8'h00, NO, rd(8'hF8));
    lock_set(8'hFF);
    chk(lockb, 8'hFC);
    chk({6'h00, mode}, 8'h03);
    op(1'b1, CODE, 10'h001, 8'hFF, CE, OK);
    idle(1);
    op(1'b0, CODE, a, 8'h00, NO, ER);
    idle(1);
    chk(lockb, 8'hFC);
    wait_idle();
    chk(lockb, 8'hFF);
    op(1'b0, CODE, a, 8'h00, NO, rd(8'hFF));
    op(1'b0, CFG, 10'h000, 8'h00, NO, rd(8'hF8));
    op(1'b1, CFG, 10'h001, 8'hFF, SE, OK);
    idle(2);
    op(1'b0, CFG, 10'h000, 8'h00, NO, rd(8'hFF));
    idle(2);
    chk({5'h00, cko, wdo, rdo}, 8'h07);
    reset_i <= 1'b1;
    idle(3);
    reset_i <= 1'b0;
    wait_idle();
    chk(trim, 8'h80);
    chk({5'h00, cko, wdo, rdo}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule : nlc_nvm_lock_cfg_tb_top
`default_nettype wire
